// *** rtl/exec_map.svh ***
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// data memory depth and program counter width
`define DMEM_DEPTH 256
`define PC_WIDTH 13
`define STACK_DEPTH 16
`define STACK_PTR_W 4
// system clocks per instruction cycle
`define CLKS_PER_CYCLE 4
`define BCD_LIMIT 4'h9
`define BCD_ADJUST 4'h6
// address of the program counter low byte in data memory space
`define PCL_ADDR 8'h06
`define WDT_CLEAR 8'h00
`define WDT_WIDTH 8
`define PRESC_WIDTH 8

`endif

// *** rtl/exec_pkg.sv ***
package exec_pkg;
    typedef enum logic [4:0] {
        OP_NOP, OP_WDT_PRE1, OP_WDT_PRE2, OP_CPL, OP_COMPLEMENT_TO_ACC_OP, OP_DAA,
        OP_DEC, OP_DECA, OP_INC, OP_INCA, OP_HALT, OP_JMP,
        OP_MOV_AX, OP_MOV_AM, OP_MOV_MA, OP_OR_AM, OP_OR_AX, OP_ORM,
        OP_RET, OP_RET_AX, OP_INTERRUPT_RETURN_OP, OP_RL, OP_RLA, OP_RLC, OP_RLCA,
        OP_RR, OP_RRA, OP_RRC, OP_RRCA
    } opcode_t;

    typedef struct packed {
        opcode_t op;
        logic [7:0] addr;
        logic [7:0] imm;
        logic [12:0] target;
    } instr_t;

    typedef struct packed {
        logic timeoutFlag;
        logic powerdownFlag;
        logic zero;
        logic carry;
        logic nibbleCarryFlag;
        logic globalIntEnable;
    } flags_t;
endpackage

// *** rtl/mcu_instruction_execute.sv ***
// Notes on behaviour
// - both pre-clears done: clear watchdog, flags
// - one pre-clear only: just remember it
// - complement memory byte, zero flag only
// - complement into accumulator, memory kept
// - low nibble add six when over nine
// - high nibble add six plus carry, set carry
// - decimal adjust writes memory, carry only
// - decrement to memory or accumulator, zero flag
// - increment to memory or accumulator, zero flag
// - accumulator forms leave memory unchanged
// - power-down: pc+1, stop, clear watchdog, set powerdown flag, clear timeout flag
// - jump loads pc, no flags
// - move immediate into accumulator, no flags
// - moves copy byte, no flags
// - no-operation only advances pc
// - or into accumulator, zero flag only
// - or into memory, zero flag only
// - return pops pc, two cycles, no flags
// - return with constant loads accumulator
// - interrupt return sets global enable
// - left rotate, bit7 to bit0
// - left rotate through carry
// - right rotate, bit0 to bit7
// - right rotate through carry
// - pcl write costs one extra cycle
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "exec_map.svh"

module mcu_instruction_execute
    import exec_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // instruction issue
    input wire logic instrValid,
    input wire instr_t instr,
    output logic instrReady,
    // processor state
    output logic [7:0] accumulator,
    output logic [`PC_WIDTH-1:0] programCounter,
    output flags_t flags,
    output logic [`WDT_WIDTH-1:0] watchdogCounter,
    output logic halted,
    // stack push from the call and interrupt logic outside
    input wire logic stackPush,
    input wire logic [`PC_WIDTH-1:0] stackPushData,
    // software view of data memory
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdData
);

    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_WAIT, S_HALT} state_t;

    logic [7:0] dmem [0:`DMEM_DEPTH-1];
    logic [`PC_WIDTH-1:0] stackMem [0:`STACK_DEPTH-1];
    logic [`STACK_PTR_W-1:0] stackPtr_reg;
    state_t state_reg;
    instr_t cur_reg;
    logic [7:0] acc_reg;
    logic [`PC_WIDTH-1:0] pc_reg;
    flags_t flags_reg;
    logic [`WDT_WIDTH-1:0] wdt_reg;
    logic [`PRESC_WIDTH-1:0] presc_reg;
    logic pre1Seen_reg;
    logic pre2Seen_reg;
    logic [3:0] clkCount_reg;
    logic [3:0] cycleLen_reg;
    logic [7:0] rdData_reg;

    logic [7:0] memByte;
    logic [7:0] result;
    logic writeMem;
    logic writeAcc;
    logic zeroUpdate;
    logic carryNext;
    logic [3:0] lowNibble;
    logic [4:0] highSum;
    logic adjCarry;
    logic [3:0] cycles;

    function automatic logic isZero(input logic [7:0] v);
        isZero = (v == 8'h00);
    endfunction

    function automatic logic [3:0] cyclesOf(input opcode_t op, input logic pclWrite);
        logic [3:0] base;
        base = 4'h1;
        if (op == OP_JMP || op == OP_RET || op == OP_RET_AX || op == OP_INTERRUPT_RETURN_OP) begin
            base = 4'h2;
        end
        cyclesOf = pclWrite ? base + 4'h1 : base;
    endfunction

    assign memByte = dmem[cur_reg.addr];
    assign instrReady = (state_reg == S_IDLE);
    assign accumulator = acc_reg;
    assign programCounter = pc_reg;
    assign flags = flags_reg;
    assign watchdogCounter = wdt_reg;
    assign halted = (state_reg == S_HALT);
    assign rdData = rdData_reg;

    // datapath for the instruction held in cur_reg
    always_comb begin
        result = 8'h00;
        writeMem = 1'b0;
        writeAcc = 1'b0;
        zeroUpdate = 1'b0;
        carryNext = flags_reg.carry;
        adjCarry = 1'b0;
        lowNibble = acc_reg[3:0];
        highSum = {1'b0, acc_reg[7:4]};
        case (cur_reg.op)
            OP_CPL: begin
                result = ~memByte;
                writeMem = 1'b1;
                zeroUpdate = 1'b1;
            end
            OP_COMPLEMENT_TO_ACC_OP: begin
                result = ~memByte;
                writeAcc = 1'b1;
                zeroUpdate = 1'b1;
            end
            OP_DAA: begin
                if (acc_reg[3:0] > `BCD_LIMIT || flags_reg.nibbleCarryFlag) begin
                    lowNibble = acc_reg[3:0] + `BCD_ADJUST;
                    adjCarry = ~flags_reg.nibbleCarryFlag;
                end
                highSum = {1'b0, acc_reg[7:4]} + {4'h0, adjCarry};
                if (highSum > {1'b0, `BCD_LIMIT} || flags_reg.carry) begin
                    highSum = highSum + {1'b0, `BCD_ADJUST};
                    carryNext = 1'b1;
                end
                result = {highSum[3:0], lowNibble};
                writeMem = 1'b1;
            end
            OP_DEC, OP_DECA: begin
                result = memByte - 8'h01;
                writeMem = (cur_reg.op == OP_DEC);
                writeAcc = (cur_reg.op == OP_DECA);
                zeroUpdate = 1'b1;
            end
            OP_INC, OP_INCA: begin
                result = memByte + 8'h01;
                writeMem = (cur_reg.op == OP_INC);
                writeAcc = (cur_reg.op == OP_INCA);
                zeroUpdate = 1'b1;
            end
            OP_MOV_AX, OP_RET_AX: begin
                result = cur_reg.imm;
                writeAcc = 1'b1;
            end
            OP_MOV_AM: begin
                result = memByte;
                writeAcc = 1'b1;
            end
            OP_MOV_MA: begin
                result = acc_reg;
                writeMem = 1'b1;
            end
            OP_OR_AM, OP_OR_AX: begin
                result = acc_reg | ((cur_reg.op == OP_OR_AM) ? memByte : cur_reg.imm);
                writeAcc = 1'b1;
                zeroUpdate = 1'b1;
            end
            OP_ORM: begin
                result = acc_reg | memByte;
                writeMem = 1'b1;
                zeroUpdate = 1'b1;
            end
            OP_RL, OP_RLA: begin
                result = {memByte[6:0], memByte[7]};
                writeMem = (cur_reg.op == OP_RL);
                writeAcc = (cur_reg.op == OP_RLA);
            end
            OP_RLC, OP_RLCA: begin
                result = {memByte[6:0], flags_reg.carry};
                carryNext = memByte[7];
                writeMem = (cur_reg.op == OP_RLC);
                writeAcc = (cur_reg.op == OP_RLCA);
            end
            OP_RR, OP_RRA: begin
                result = {memByte[0], memByte[7:1]};
                writeMem = (cur_reg.op == OP_RR);
                writeAcc = (cur_reg.op == OP_RRA);
            end
            OP_RRC, OP_RRCA: begin
                result = {flags_reg.carry, memByte[7:1]};
                carryNext = memByte[0];
                writeMem = (cur_reg.op == OP_RRC);
                writeAcc = (cur_reg.op == OP_RRCA);
            end
            default: begin
                result = 8'h00;
            end
        endcase
    end

    assign cycles = cyclesOf(cur_reg.op, writeMem && cur_reg.addr == `PCL_ADDR);

    // sequencing: the instruction commits in S_EXEC, then waits out its cycles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
            cur_reg <= '0;
            clkCount_reg <= 4'h0;
            cycleLen_reg <= 4'h0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (instrValid) begin
                        cur_reg <= instr;
                        state_reg <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    cycleLen_reg <= cycles;
                    clkCount_reg <= 4'h3; // the next edge is the third since the take
                    // halt stops the clock; modelled as a state nothing leaves but reset
                    state_reg <= (cur_reg.op == OP_HALT) ? S_HALT : S_WAIT;
                end
                S_WAIT: begin
                    clkCount_reg <= clkCount_reg + 4'h1;
                    if (clkCount_reg >= 4'(cycleLen_reg * `CLKS_PER_CYCLE)) begin
                        state_reg <= S_IDLE;
                    end
                end
                S_HALT: begin
                    state_reg <= S_HALT;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // accumulator
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg <= 8'h00;
        end else if (state_reg == S_EXEC && writeAcc) begin
            acc_reg <= result;
        end
    end

    // data memory; software writes are blocked only in the S_EXEC cycle, software reads are served in any state
    always_ff @(posedge clk) begin
        if (state_reg == S_EXEC && writeMem) begin
            dmem[cur_reg.addr] <= result;
        end else if (wrStrobe && state_reg != S_EXEC) begin
            dmem[addr] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_reg <= 8'h00;
        end else if (rdStrobe) begin
            rdData_reg <= dmem[addr];
        end
    end

    // program counter and stack
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_reg <= '0;
            stackPtr_reg <= '0;
        end else if (state_reg == S_EXEC) begin
            case (cur_reg.op)
                OP_JMP: pc_reg <= cur_reg.target;
                OP_RET, OP_RET_AX, OP_INTERRUPT_RETURN_OP: begin
                    pc_reg <= stackMem[stackPtr_reg - 4'h1];
                    stackPtr_reg <= stackPtr_reg - 4'h1;
                end
                default: pc_reg <= pc_reg + 13'h0001;
            endcase
        end else if (stackPush) begin
            stackPtr_reg <= stackPtr_reg + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (stackPush && state_reg != S_EXEC) begin
            stackMem[stackPtr_reg] <= stackPushData;
        end
    end

    // flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_reg <= '0;
        end else if (state_reg == S_EXEC) begin
            if (zeroUpdate) begin
                flags_reg.zero <= isZero(result);
            end
            flags_reg.carry <= carryNext;
            if (cur_reg.op == OP_INTERRUPT_RETURN_OP) begin
                flags_reg.globalIntEnable <= 1'b1;
            end
            if (cur_reg.op == OP_HALT) begin
                flags_reg.powerdownFlag <= 1'b1;
                flags_reg.timeoutFlag <= 1'b0;
            end else if ((cur_reg.op == OP_WDT_PRE1 && pre2Seen_reg) ||
                         (cur_reg.op == OP_WDT_PRE2 && pre1Seen_reg)) begin
                flags_reg.powerdownFlag <= 1'b0;
                flags_reg.timeoutFlag <= 1'b0;
            end
        end
    end

    // watchdog pre-clear pairing; a pair clears both memories
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre1Seen_reg <= 1'b0;
            pre2Seen_reg <= 1'b0;
        end else if (state_reg == S_EXEC) begin
            if (cur_reg.op == OP_WDT_PRE1) begin
                pre1Seen_reg <= ~pre2Seen_reg;
                if (pre2Seen_reg) begin
                    pre2Seen_reg <= 1'b0;
                end
            end else if (cur_reg.op == OP_WDT_PRE2) begin
                pre2Seen_reg <= ~pre1Seen_reg;
                if (pre1Seen_reg) begin
                    pre1Seen_reg <= 1'b0;
                end
            end
        end
    end

    // watchdog counts system clocks, one step per 256 through the prescaler here; timeout logic lives elsewhere
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdt_reg <= `WDT_CLEAR;
            presc_reg <= '0;
        end else if (state_reg == S_EXEC && (cur_reg.op == OP_HALT ||
                     (cur_reg.op == OP_WDT_PRE1 && pre2Seen_reg) ||
                     (cur_reg.op == OP_WDT_PRE2 && pre1Seen_reg))) begin
            wdt_reg <= `WDT_CLEAR;
            presc_reg <= '0;
        end else if (state_reg != S_HALT) begin
            presc_reg <= presc_reg + 8'h01;
            if (presc_reg == 8'hff) begin
                wdt_reg <= wdt_reg + 8'h01;
            end
        end
    end

    pre_pair_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_WDT_PRE2 && pre1Seen_reg
        |=> wdt_reg == 8'h00 && !flags_reg.timeoutFlag && !flags_reg.powerdownFlag)
        else $error("paired pre-clear did not clear watchdog");
    pre_single_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_WDT_PRE1 && !pre2Seen_reg
        |=> pre1Seen_reg && $stable(flags_reg.timeoutFlag) && $stable(flags_reg.powerdownFlag))
        else $error("single pre-clear changed flags");
    cpl_acc_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_COMPLEMENT_TO_ACC_OP |=> acc_reg == ~$past(memByte))
        else $error("complement to accumulator wrong");
    daa_carry_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_DAA && flags_reg.carry |=> flags_reg.carry)
        else $error("decimal adjust lost carry");
    halt_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_HALT
        |=> halted && flags_reg.powerdownFlag && pc_reg == $past(pc_reg) + 13'h0001 ##1 halted)
        else $error("power-down entry wrong");
    jump_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_JMP |=> pc_reg == $past(cur_reg.target))
        else $error("jump target not loaded");
    ret_len_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_RET && cur_reg.addr != `PCL_ADDR
        |=> !instrReady [*6] ##1 instrReady)
        else $error("return did not take two cycles");
    interrupt_return_op_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_INTERRUPT_RETURN_OP |=> flags_reg.globalIntEnable)
        else $error("interrupt return left enable clear");
    rlc_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_RLCA
        |=> flags_reg.carry == $past(memByte[7]) && acc_reg[0] == $past(flags_reg.carry))
        else $error("left rotate through carry wrong");
    zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_OR_AX |=> flags_reg.zero == (acc_reg == 8'h00))
        else $error("zero flag mismatch");

    halt_c: cover property (@(posedge clk) disable iff (!reset_n) halted);
    pair_c: cover property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_WDT_PRE2 && pre1Seen_reg);
    daa_c: cover property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_DAA && adjCarry);
    interrupt_return_op_c: cover property (@(posedge clk) disable iff (!reset_n)
        state_reg == S_EXEC && cur_reg.op == OP_INTERRUPT_RETURN_OP);

endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "exec_map.svh"

module testbench
    import exec_pkg::*;
;
    logic clk;
    logic reset_n;
    logic instrValid;
    instr_t instr;
    logic instrReady;
    logic [7:0] accumulator;
    logic [`PC_WIDTH-1:0] programCounter;
    flags_t flags;
    logic [`WDT_WIDTH-1:0] watchdogCounter;
    logic halted;
    logic stackPush;
    logic [`PC_WIDTH-1:0] stackPushData;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic [7:0] rdData;

    int mismatches = 0;
    int samplesChecked = 0;
    int seed = 53;
    // behavioural model of the architectural state
    logic [7:0] mAcc;
    logic [12:0] mPc;
    flags_t mF;
    logic [7:0] mem [256];
    logic [12:0] stk [$];
    opcode_t pclOps[3] = '{OP_INC, OP_MOV_MA, OP_ORM};

    mcu_instruction_execute i_mcu_instruction_execute (
        .clk(clk), .reset_n(reset_n), .instrValid(instrValid), .instr(instr),
        .instrReady(instrReady), .accumulator(accumulator), .programCounter(programCounter),
        .flags(flags), .watchdogCounter(watchdogCounter), .halted(halted),
        .stackPush(stackPush), .stackPushData(stackPushData), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic complete_run();
        $display("mismatches %0d samplesChecked %0d", mismatches, samplesChecked);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic note(bit ok, string what);
        samplesChecked++;
        if (!ok) begin
            mismatches++;
            $display("FAIL t=%0t %s", $time, what);
        end
    endtask

    task automatic cmpByte(logic [7:0] got, logic [7:0] exp, string what);
        note(got === exp, $sformatf("%s got %h exp %h", what, got, exp));
    endtask
    task automatic cmpPc(logic [12:0] got, logic [12:0] exp);
        note(got === exp, $sformatf("pc got %h exp %h", got, exp));
    endtask
    task automatic cmpFlags(flags_t got, flags_t exp);
        note(got === exp, $sformatf("flags got %b exp %b", got, exp));
    endtask
    task automatic cmpBit(logic got, logic exp, string what);
        note(got === exp, what);
    endtask
    task automatic cmpCount(int got, int exp);
        note(got == exp, $sformatf("busy clocks got %0d exp %0d", got, exp));
    endtask

    task automatic writeRam(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        wrStrobe <= 1'b1;
        addr <= a;
        wrData <= d;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask

    task automatic readRam(logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rdStrobe <= 1'b1;
        addr <= a;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 d = rdData;
    endtask

    task automatic pushStack(logic [12:0] d);
        @(posedge clk);
        stackPush <= 1'b1;
        stackPushData <= d;
        @(posedge clk);
        stackPush <= 1'b0;
        stk.push_back(d);
    endtask

    // offer one instruction, count clocks until the port is idle again, or until halted for OP_HALT
    task automatic exec(opcode_t o, logic [7:0] a, logic [7:0] im, logic [12:0] tg,
                        output int n);
        int k;
        @(posedge clk);
        instrValid <= 1'b1;
        instr <= '{op: o, addr: a, imm: im, target: tg};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (instrReady !== 1'b1 && k < 50);
        instrValid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (((o == OP_HALT) ? halted : instrReady) !== 1'b1 && n < 50);
        #1;
    endtask

    task automatic run(opcode_t o, logic [7:0] a, logic [7:0] m, logic [7:0] im,
                       logic [12:0] tg, bit chkPc);
        logic [7:0] r;
        logic [7:0] got;
        logic [4:0] lo;
        logic [4:0] hi;
        logic ac1;
        bit toMem;
        bit toAcc;
        bit zf;
        int cyc;
        int n;
        logic [12:0] npc;
        writeRam(a, m);
        mem[a] = m;
        if (o inside {OP_RET, OP_RET_AX, OP_INTERRUPT_RETURN_OP}) pushStack(13'($random(seed)));
        r = 8'h00;
        toMem = 0;
        toAcc = 0;
        zf = 0;
        cyc = 1;
        npc = mPc + 13'd1;
        case (o)
            OP_CPL: begin r = ~m; toMem = 1; zf = 1; end
            OP_COMPLEMENT_TO_ACC_OP: begin r = ~m; toAcc = 1; zf = 1; end
            OP_DAA: begin
                lo = {1'b0, mAcc[3:0]};
                hi = {1'b0, mAcc[7:4]};
                if (lo > 5'd9 || mF.nibbleCarryFlag) begin
                    lo = lo + 5'd6;
                    ac1 = ~mF.nibbleCarryFlag;
                end else ac1 = 1'b0;
                if (hi + 5'(ac1) > 5'd9 || mF.carry) begin
                    hi = hi + 5'd6 + 5'(ac1);
                    mF.carry = 1'b1;
                end else hi = hi + 5'(ac1);
                r = {hi[3:0], lo[3:0]};
                toMem = 1;
            end
            OP_DEC: begin r = m - 8'h01; toMem = 1; zf = 1; end
            OP_DECA: begin r = m - 8'h01; toAcc = 1; zf = 1; end
            OP_INC: begin r = m + 8'h01; toMem = 1; zf = 1; end
            OP_INCA: begin r = m + 8'h01; toAcc = 1; zf = 1; end
            OP_JMP: begin npc = tg; cyc = 2; end
            OP_MOV_AX: begin r = im; toAcc = 1; end
            OP_MOV_AM: begin r = m; toAcc = 1; end
            OP_MOV_MA: begin r = mAcc; toMem = 1; end
            OP_OR_AM: begin r = mAcc | m; toAcc = 1; zf = 1; end
            OP_OR_AX: begin r = mAcc | im; toAcc = 1; zf = 1; end
            OP_ORM: begin r = mAcc | m; toMem = 1; zf = 1; end
            OP_RET, OP_RET_AX, OP_INTERRUPT_RETURN_OP: begin
                npc = stk.pop_back();
                cyc = 2;
                if (o == OP_RET_AX) begin r = im; toAcc = 1; end
                if (o == OP_INTERRUPT_RETURN_OP) mF.globalIntEnable = 1'b1;
            end
            OP_RL, OP_RLA: begin r = {m[6:0], m[7]}; toMem = (o == OP_RL); toAcc = !toMem; end
            OP_RLC, OP_RLCA: begin
                r = {m[6:0], mF.carry};
                mF.carry = m[7];
                toMem = (o == OP_RLC);
                toAcc = !toMem;
            end
            OP_RR, OP_RRA: begin r = {m[0], m[7:1]}; toMem = (o == OP_RR); toAcc = !toMem; end
            OP_RRC, OP_RRCA: begin
                r = {mF.carry, m[7:1]};
                mF.carry = m[0];
                toMem = (o == OP_RRC);
                toAcc = !toMem;
            end
            default: ;
        endcase
        if (toMem) mem[a] = r;
        if (toAcc) mAcc = r;
        if (zf) mF.zero = (r == 8'h00);
        if (toMem && a == `PCL_ADDR) cyc++;
        mPc = npc;
        exec(o, a, im, tg, n);
        cmpCount(n, cyc * `CLKS_PER_CYCLE);
        cmpByte(accumulator, mAcc, "acc");
        if (chkPc) cmpPc(programCounter, mPc);
        cmpFlags(flags, mF);
        readRam(a, got);
        cmpByte(got, mem[a], "mem");
    endtask

    initial begin
        reset_n = 1'b0;
        instrValid = 1'b0;
        instr = '0;
        stackPush = 1'b0;
        stackPushData = '0;
        addr = 8'h00;
        wrData = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        mAcc = 8'h00;
        mPc = '0;
        mF = '0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        // every code but the two pre-clears and halt in turn, boundary bytes first, then random ones
        for (int i = 0; i < 232; i++) begin
            logic [7:0] m;
            int k;
            k = i % 29;
            if (k == 1 || k == 2 || k == 10) continue;
            m = (i < 58) ? 8'hFF : (i < 116) ? 8'h00 : (i < 145) ? 8'h01 : 8'($random(seed));
            run(OP_MOV_AX, 8'h20, 8'h00, 8'($random(seed)), '0, 1);
            run(opcode_t'(k), 8'h20 + 8'(i % 32), m, 8'($random(seed)),
                13'($random(seed)), 1);
        end
        // writes that land on the program counter low byte cost a cycle
        foreach (pclOps[j]) begin
            run(pclOps[j], `PCL_ADDR, 8'h3C, 8'h00, '0, 0);
            run(OP_JMP, 8'h20, 8'h00, 8'h00, 13'h0100 + 13'(j), 1);
        end
        // pre-clears pair only when both kinds have run, in either order
        for (int j = 0; j < 2; j++) begin
            repeat (600) @(posedge clk);
            run(j ? OP_WDT_PRE2 : OP_WDT_PRE1, 8'h20, 8'h00, 8'h00, '0, 1);
            cmpBit(watchdogCounter != 8'h00, 1'b1, "watchdog cleared by one pre-clear");
            run(j ? OP_WDT_PRE2 : OP_WDT_PRE1, 8'h20, 8'h00, 8'h00, '0, 1);
            cmpBit(watchdogCounter != 8'h00, 1'b1, "repeated pre-clear paired");
            run(j ? OP_WDT_PRE1 : OP_WDT_PRE2, 8'h20, 8'h00, 8'h00, '0, 1);
            cmpBit(watchdogCounter <= 8'h01, 1'b1, "watchdog not cleared by pair");
        end
        begin
            int n;
            repeat (600) @(posedge clk);
            exec(OP_HALT, 8'h20, 8'h00, '0, n);
            mF.powerdownFlag = 1'b1;
            mF.timeoutFlag = 1'b0;
            cmpBit(halted, 1'b1, "not halted");
            cmpPc(programCounter, mPc + 13'd1);
            cmpFlags(flags, mF);
            cmpByte(watchdogCounter, `WDT_CLEAR, "watchdog");
            cmpByte(accumulator, mAcc, "acc kept");
        end
        complete_run();
    end

    initial begin
        #(4 * 40000);
        mismatches++;
        complete_run();
    end
endmodule
